//--- core/pspc_pkg.sv
// Constants, register map and state codes for the pump staging controller
// Operation
// RL1: Zero fill duration disables the fill phase
// RL2: Clamp commanded frequency to fill cap
// RL3: Switch setup: end fill on time/pressure
// RL4: Analog setup: end fill above exit pressure
// RL5: Operator sets fill exit below target
// RL6: Fill starts on every off-to-run transition
// RL7: Aux control only when count above zero
// RL8: Aux control suppresses other relay functions
// RL9: Aux parameters only in analog setup
// RL10: Call pumps in ascending relay order
// RL11: Stage in at target minus stage margin
// RL12: Stage in after stage hold-off expires
// RL13: Stage in closes that pump's relay
// RL14: Release at target plus release margin
// RL15: Release after release hold-off expires
// RL16: Release needs frequency inside release window
// RL17: Release opens that pump's relay
// RL18: After release command minimum plus bump
// RL19: Hold bump for duration, then regulate
// RL20: Fill energizes configured fill pump relays
// RL21: Operator keeps fill pumps within aux count
// RL22: Release most recently staged relay first
// RL23: Hold-off timers restart when condition drops
package pspc_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 4;
    localparam int unsigned SEC_NS = 1_000_000_000;
    localparam int unsigned SEC_CYC = SEC_NS / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] OFS_CFG = 8'h00;
    localparam logic [7:0] OFS_FILL = 8'h04;
    localparam logic [7:0] OFS_PRES = 8'h08;
    localparam logic [7:0] OFS_MARG = 8'h0C;
    localparam logic [7:0] OFS_DLY = 8'h10;
    localparam logic [7:0] OFS_FRQ = 8'h14;
    localparam logic [7:0] OFS_BUMP = 8'h18;
    localparam logic [7:0] OFS_STAT = 8'h1C;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int unsigned CFG_ANALOG = 0;
    localparam int unsigned CFG_AUXN_LSB = 1;
    localparam int unsigned CFG_FILLN_LSB = 4;
    localparam int unsigned CFG_GEN_LSB = 8;
    localparam int unsigned HALF_LO = 0;
    localparam int unsigned HALF_HI = 16;
    localparam int unsigned DLY_STG_LSB = 0;
    localparam int unsigned DLY_REL_LSB = 8;
    localparam int unsigned DLY_BMP_LSB = 16;
    localparam int unsigned STAT_N_LSB = 4;
    localparam int unsigned STAT_ST_LSB = 8;
    localparam int unsigned STAT_AUX = 12;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [31:0] RST_CFG = 32'h0000_0000;
    localparam logic [31:0] RST_FILL = 32'h0000_0000;
    localparam logic [31:0] RST_PRES = 32'h0000_0000;
    localparam logic [31:0] RST_MARG = 32'h0000_0000;
    localparam logic [31:0] RST_DLY = 32'h0000_0000;
    localparam logic [31:0] RST_FRQ = 32'h0000_0000;
    localparam logic [31:0] RST_BUMP = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Bus answers and counts
    // ----------------------------------------------------------------
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [2:0] AUX_MAX = 3'h4;

    typedef enum logic [3:0] {
        ST_OFF = 4'h1,
        ST_FILL = 4'h2,
        ST_RUN = 4'h4,
        ST_BUMP = 4'h8
    } pspc_state_e;

endpackage

//--- core/pspc_hold.sv
// Seconds hold-off timer that restarts whenever its run input drops
`timescale 1ns/1ns
module pspc_hold #(
    parameter int unsigned W = 16
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_n_s, // Synchronised reset
    input wire logic tick, // One-second enable pulse
    input wire logic run, // Condition holds
    input wire logic [W-1:0] limit, // Seconds to wait
    output logic done // Wait is over
);
    import pspc_pkg::*;

    typedef struct packed {
        logic [W-1:0] cnt;
    } pspc_hold_s;

    pspc_hold_s q_ff;
    pspc_hold_s nxt_q;

    initial begin
        if (W < 1 || W > 32) $error("pspc_hold: W out of range");
    end

    // Count seconds while running, clear as soon as the condition drops
    always_comb begin
        nxt_q = q_ff;
        if (!run) begin
            nxt_q.cnt = '0; // [RL23]
        end else if (tick && q_ff.cnt != limit) begin
            nxt_q.cnt = q_ff.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n_s) begin
        if (!rst_n_s) begin
            q_ff <= '0;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // Partial count never reaches the limit, so a dip costs a full restart
    assign done = run && q_ff.cnt == limit;

    a_timer_restart: assert property (@(posedge clk_sys) disable iff (!rst_n_s)
        !run |=> q_ff.cnt == '0) // [RL23]
        else $error("hold timer kept count after condition dropped");

endmodule // pspc_hold

//--- core/pspc_ctrl.sv
// Fill phase and auxiliary pump staging controller with AXI4-Lite registers
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ns
module pspc_ctrl #(
    parameter int unsigned TICK_CYC = pspc_pkg::SEC_CYC
) (
    input wire logic clk_sys, // 250 MHz clock
    input wire logic rst_n, // Async reset, active low
    input wire logic run_auto, // Automatic mode pin
    input wire logic run_manual, // Manual run pin
    input wire logic press_switch, // Control pressure reached pin
    input wire logic [15:0] pressure_meas, // Measured pressure
    input wire logic [15:0] master_freq, // Master drive frequency
    output logic [3:0] relay_out, // Relay drives, 1 = closed
    output logic [15:0] freq_cap, // Fill frequency cap
    output logic freq_cap_on, // Cap applies
    output logic [15:0] freq_override, // Forced master frequency
    output logic freq_override_on, // Override applies
    input wire logic s_axi_awvalid, // AXI write address valid
    output logic s_axi_awready, // AXI write address ready
    input wire logic [7:0] s_axi_awaddr, // AXI write address
    input wire logic s_axi_wvalid, // AXI write data valid
    output logic s_axi_wready, // AXI write data ready
    input wire logic [31:0] s_axi_wdata, // AXI write data
    input wire logic [3:0] s_axi_wstrb, // AXI byte strobes
    output logic s_axi_bvalid, // AXI write response valid
    input wire logic s_axi_bready, // AXI write response ready
    output logic [1:0] s_axi_bresp, // AXI write response
    input wire logic s_axi_arvalid, // AXI read address valid
    output logic s_axi_arready, // AXI read address ready
    input wire logic [7:0] s_axi_araddr, // AXI read address
    output logic s_axi_rvalid, // AXI read data valid
    input wire logic s_axi_rready, // AXI read data ready
    output logic [31:0] s_axi_rdata, // AXI read data
    output logic [1:0] s_axi_rresp // AXI read response
);
    import pspc_pkg::*;

    initial begin
        if (TICK_CYC < 2) $error("pspc_ctrl: TICK_CYC below 2");
    end

    typedef struct packed {
        pspc_state_e st;
        logic [1:0] sy_auto;
        logic [1:0] sy_man;
        logic [1:0] sy_psw;
        logic on_d;
        logic [2:0] n;
        logic [31:0] cfg;
        logic [31:0] fill;
        logic [31:0] pres;
        logic [31:0] marg;
        logic [31:0] dly;
        logic [31:0] frq;
        logic [31:0] bump;
        logic aw_h;
        logic w_h;
        logic [7:0] awa;
        logic [31:0] wd;
        logic [3:0] ws;
        logic bv;
        logic [1:0] br;
        logic rv;
        logic [31:0] rd;
        logic [1:0] rr;
        logic [31:0] tcnt;
        logic tick;
        logic [3:0] relay;
        logic cap_on;
        logic [15:0] ovr;
        logic ovr_on;
        logic stg_d;
    } pspc_ctrl_s;

    pspc_ctrl_s q_ff;
    pspc_ctrl_s nxt_q;
    logic [1:0] rst_q_ff;
    logic rst_s;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    // Lowest n relays closed, so pumps come in from relay 1 upward
    function automatic logic [3:0] thermo(input logic [2:0] k);
        logic [2:0] c;
        c = (k > AUX_MAX) ? AUX_MAX : k;
        thermo = 4'(5'h0F >> (3'h4 - c));
    endfunction

    function automatic logic [16:0] add17(input logic [15:0] a,
                                          input logic [15:0] b);
        add17 = {1'b0, a} + {1'b0, b};
    endfunction

    function automatic logic [31:0] merge(input logic [31:0] o,
                                          input logic [31:0] v,
                                          input logic [3:0] s);
        merge = o;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) merge[i*8 +: 8] = v[i*8 +: 8];
        end
    endfunction

    function automatic logic [15:0] hi16(input logic [31:0] x);
        hi16 = x[HALF_HI +: 16];
    endfunction

    function automatic logic [15:0] lo16(input logic [31:0] x);
        lo16 = x[HALF_LO +: 16];
    endfunction

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    // Release through two flops so no flop sees a partial reset edge
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rst_q_ff <= 2'h0;
        end else begin
            rst_q_ff <= {rst_q_ff[0], 1'b1};
        end
    end
    assign rst_s = rst_q_ff[1];

    // ----------------------------------------------------------------
    // Decoded conditions
    // ----------------------------------------------------------------
    logic on_now, start, analog, aux_en, psw;
    logic [2:0] auxn, filln;
    logic [15:0] target, exitp;
    logic fill_hit, stage_c, rel_c, stage_run, rel_run;
    logic fill_done, stage_done, rel_done, bump_done;
    logic stage_go, rel_go;
    logic [16:0] bump_sum, win_top;

    assign on_now = q_ff.sy_auto[1] | q_ff.sy_man[1];
    assign start = on_now & ~q_ff.on_d;
    assign psw = q_ff.sy_psw[1];
    assign analog = q_ff.cfg[CFG_ANALOG];
    assign auxn = q_ff.cfg[CFG_AUXN_LSB +: 3];
    assign filln = q_ff.cfg[CFG_FILLN_LSB +: 3];
    assign target = lo16(q_ff.pres);
    assign exitp = hi16(q_ff.pres);
    assign aux_en = analog && auxn != 3'h0; // [RL7] [RL9]
    // Switch setups end on the switch; analog also on target or exit
    assign fill_hit = analog ? (psw || pressure_meas >= target ||
                                pressure_meas > exitp) // [RL4]
                             : psw; // [RL3]
    assign stage_c = add17(pressure_meas, lo16(q_ff.marg))
                     <= {1'b0, target}; // [RL11]
    assign win_top = add17(lo16(q_ff.frq), hi16(q_ff.frq));
    assign rel_c = {1'b0, pressure_meas} >= add17(target, hi16(q_ff.marg))
                   && master_freq >= lo16(q_ff.frq)
                   && {1'b0, master_freq} <= win_top; // [RL14] [RL16]
    assign stage_run = q_ff.st == ST_RUN && aux_en && stage_c
                       && q_ff.n < auxn && q_ff.n < AUX_MAX;
    assign rel_run = q_ff.st == ST_RUN && aux_en && rel_c
                     && q_ff.n != 3'h0;
    assign stage_go = stage_run && stage_done; // [RL12]
    assign rel_go = rel_run && rel_done && !stage_run; // [RL15]
    assign bump_sum = add17(lo16(q_ff.frq), lo16(q_ff.bump));

    // ----------------------------------------------------------------
    // Hold-off and duration timers
    // ----------------------------------------------------------------
    pspc_hold #(.W(16)) u_fill (
        .clk_sys(clk_sys),
        .rst_n_s(rst_s),
        .tick(q_ff.tick),
        .run(q_ff.st == ST_FILL),
        .limit(hi16(q_ff.fill)),
        .done(fill_done)
    );
    // Idle one cycle after each stage so every pump waits a full hold-off
    pspc_hold #(.W(8)) u_stage (
        .clk_sys(clk_sys),
        .rst_n_s(rst_s),
        .tick(q_ff.tick),
        .run(stage_run && !q_ff.stg_d), // [RL12] [RL23]
        .limit(q_ff.dly[DLY_STG_LSB +: 8]),
        .done(stage_done)
    );
    pspc_hold #(.W(8)) u_rel (
        .clk_sys(clk_sys),
        .rst_n_s(rst_s),
        .tick(q_ff.tick),
        .run(rel_run),
        .limit(q_ff.dly[DLY_REL_LSB +: 8]),
        .done(rel_done)
    );
    pspc_hold #(.W(8)) u_bump (
        .clk_sys(clk_sys),
        .rst_n_s(rst_s),
        .tick(q_ff.tick),
        .run(q_ff.st == ST_BUMP),
        .limit(q_ff.dly[DLY_BMP_LSB +: 8]),
        .done(bump_done)
    );

    // ----------------------------------------------------------------
    // Next state: pins, tick, sequencer, outputs, bus slave
    // ----------------------------------------------------------------
    always_comb begin
        nxt_q = q_ff;
        nxt_q.sy_auto = {q_ff.sy_auto[0], run_auto};
        nxt_q.sy_man = {q_ff.sy_man[0], run_manual};
        nxt_q.sy_psw = {q_ff.sy_psw[0], press_switch};
        nxt_q.on_d = on_now;
        nxt_q.stg_d = stage_go; // [RL12]
        // One-second enable from a free divider
        nxt_q.tick = 1'b0;
        nxt_q.tcnt = q_ff.tcnt + 32'h1;
        if (q_ff.tcnt == 32'(TICK_CYC - 1)) begin
            nxt_q.tcnt = 32'h0;
            nxt_q.tick = 1'b1;
        end
        // Sequencer
        unique case (q_ff.st)
            ST_OFF: begin
                nxt_q.n = 3'h0;
                if (start) begin
                    nxt_q.st = (hi16(q_ff.fill) != 16'h0) ? ST_FILL
                                                          : ST_RUN; // [RL1] [RL6]
                end
            end
            ST_FILL: begin
                if (fill_done || fill_hit) nxt_q.st = ST_RUN; // [RL3] [RL4]
            end
            ST_RUN: begin
                if (stage_go) begin
                    nxt_q.n = q_ff.n + 3'h1; // [RL10] [RL13]
                end else if (rel_go) begin
                    nxt_q.n = q_ff.n - 3'h1; // [RL17] [RL22]
                    nxt_q.st = ST_BUMP;
                end
            end
            ST_BUMP: begin
                if (bump_done) nxt_q.st = ST_RUN; // [RL19]
            end
            default: nxt_q.st = ST_OFF;
        endcase
        if (!on_now) begin
            nxt_q.st = ST_OFF;
            nxt_q.n = 3'h0;
        end
        // Outputs follow the next state so they align with it
        if (nxt_q.st == ST_FILL) begin
            nxt_q.relay = thermo(filln); // [RL20]
        end else if (aux_en) begin
            nxt_q.relay = thermo(nxt_q.n); // [RL8] [RL13] [RL17]
        end else begin
            nxt_q.relay = q_ff.cfg[CFG_GEN_LSB +: 4];
        end
        nxt_q.cap_on = nxt_q.st == ST_FILL; // [RL2]
        nxt_q.ovr_on = nxt_q.st == ST_BUMP; // [RL18]
        nxt_q.ovr = bump_sum[16] ? 16'hFFFF : bump_sum[15:0];
        // Write channel: address and data taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            nxt_q.aw_h = 1'b1;
            nxt_q.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            nxt_q.w_h = 1'b1;
            nxt_q.wd = s_axi_wdata;
            nxt_q.ws = s_axi_wstrb;
        end
        if (q_ff.bv && s_axi_bready) nxt_q.bv = 1'b0;
        if (q_ff.aw_h && q_ff.w_h) begin
            nxt_q.aw_h = 1'b0;
            nxt_q.w_h = 1'b0;
            nxt_q.bv = 1'b1;
            nxt_q.br = RESP_OKAY;
            // Aux tuning is locked unless the analog setup is chosen
            unique case ({q_ff.awa[7:2], 2'h0})
                OFS_CFG: nxt_q.cfg = merge(q_ff.cfg, q_ff.wd, q_ff.ws);
                OFS_FILL: nxt_q.fill = merge(q_ff.fill, q_ff.wd, q_ff.ws);
                OFS_PRES: nxt_q.pres = merge(q_ff.pres, q_ff.wd, q_ff.ws);
                OFS_MARG: if (analog) begin
                    nxt_q.marg = merge(q_ff.marg, q_ff.wd, q_ff.ws); // [RL9]
                end
                OFS_DLY: if (analog) begin
                    nxt_q.dly = merge(q_ff.dly, q_ff.wd, q_ff.ws);
                end
                OFS_FRQ: if (analog) begin
                    nxt_q.frq = merge(q_ff.frq, q_ff.wd, q_ff.ws);
                end
                OFS_BUMP: if (analog) begin
                    nxt_q.bump = merge(q_ff.bump, q_ff.wd, q_ff.ws);
                end
                OFS_STAT: ;
                default: nxt_q.br = RESP_SLVERR;
            endcase
        end
        // Read channel: one-cycle answer, unmapped reads zero
        if (q_ff.rv && s_axi_rready) nxt_q.rv = 1'b0;
        if (s_axi_arvalid && s_axi_arready) begin
            nxt_q.rv = 1'b1;
            nxt_q.rr = RESP_OKAY;
            unique case ({s_axi_araddr[7:2], 2'h0})
                OFS_CFG: nxt_q.rd = q_ff.cfg;
                OFS_FILL: nxt_q.rd = q_ff.fill;
                OFS_PRES: nxt_q.rd = q_ff.pres;
                OFS_MARG: nxt_q.rd = q_ff.marg;
                OFS_DLY: nxt_q.rd = q_ff.dly;
                OFS_FRQ: nxt_q.rd = q_ff.frq;
                OFS_BUMP: nxt_q.rd = q_ff.bump;
                OFS_STAT: begin
                    nxt_q.rd = 32'h0;
                    nxt_q.rd[3:0] = q_ff.relay;
                    nxt_q.rd[STAT_N_LSB +: 3] = q_ff.n;
                    nxt_q.rd[STAT_ST_LSB +: 4] = q_ff.st;
                    nxt_q.rd[STAT_AUX] = aux_en;
                end
                default: begin
                    nxt_q.rd = 32'h0;
                    nxt_q.rr = RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_s) begin
        if (!rst_s) begin
            q_ff <= '0;
            q_ff.st <= ST_OFF;
            q_ff.cfg <= RST_CFG;
            q_ff.fill <= RST_FILL;
            q_ff.pres <= RST_PRES;
            q_ff.marg <= RST_MARG;
            q_ff.dly <= RST_DLY;
            q_ff.frq <= RST_FRQ;
            q_ff.bump <= RST_BUMP;
        end else begin
            q_ff <= nxt_q;
        end
    end

    // Handshakes combinational, payloads from flops
    assign s_axi_awready = !q_ff.aw_h && !q_ff.bv;
    assign s_axi_wready = !q_ff.w_h && !q_ff.bv;
    assign s_axi_arready = !q_ff.rv;
    assign s_axi_bvalid = q_ff.bv;
    assign s_axi_bresp = q_ff.br;
    assign s_axi_rvalid = q_ff.rv;
    assign s_axi_rdata = q_ff.rd;
    assign s_axi_rresp = q_ff.rr;
    assign relay_out = q_ff.relay;
    assign freq_cap = lo16(q_ff.fill); // [RL2]
    assign freq_cap_on = q_ff.cap_on;
    assign freq_override = q_ff.ovr; // [RL18]
    assign freq_override_on = q_ff.ovr_on;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_s);

    // On_now in the decision cycle fixes the next state, so no raw pins
    sequence s_start_off;
        q_ff.st == ST_OFF && start;
    endsequence
    sequence s_release;
        q_ff.st == ST_RUN && rel_go && on_now;
    endsequence

    a_fill_skip: assert property ( // [RL1]
        s_start_off and (hi16(q_ff.fill) == 16'h0) |=> q_ff.st == ST_RUN)
        else $error("fill phase entered with zero duration");
    a_fill_start: assert property ( // [RL6]
        s_start_off and (hi16(q_ff.fill) != 16'h0) |=> q_ff.st == ST_FILL)
        else $error("fill phase missed on start");
    a_fill_cap: assert property ( // [RL2]
        q_ff.st == ST_FILL |-> freq_cap_on && freq_cap == lo16(q_ff.fill))
        else $error("fill frequency cap not applied");
    a_fill_switch: assert property ( // [RL3]
        q_ff.st == ST_FILL && psw |=> q_ff.st != ST_FILL)
        else $error("fill not ended on control pressure");
    a_fill_exit: assert property ( // [RL4]
        q_ff.st == ST_FILL && analog && pressure_meas > exitp
        |=> q_ff.st != ST_FILL)
        else $error("fill not ended above exit pressure");
    // Relays follow the config seen when they were computed
    a_relay_gate: assert property ( // [RL7]
        !aux_en && !start && q_ff.st != ST_FILL
        |=> relay_out == $past(q_ff.cfg[CFG_GEN_LSB +: 4]))
        else $error("relays taken without aux control");
    a_stage_step: assert property ( // [RL10] [RL13]
        stage_go && on_now |=> q_ff.n == $past(q_ff.n) + 3'h1
        && relay_out == thermo(q_ff.n))
        else $error("stage-in did not close next relay");
    a_release_bump: assert property ( // [RL17] [RL18] [RL22]
        s_release |=> q_ff.st == ST_BUMP && freq_override_on
        && relay_out == thermo(q_ff.n) && q_ff.n == $past(q_ff.n) - 3'h1)
        else $error("release did not open relay and bump");
    a_bump_hold: assert property ( // [RL19]
        q_ff.st == ST_BUMP && !bump_done && on_now |=> q_ff.st == ST_BUMP)
        else $error("bump left before its duration");
    a_fill_relays: assert property ( // [RL20]
        q_ff.st == ST_FILL |-> relay_out == thermo($past(filln)))
        else $error("fill pump relays not energized");

endmodule // pspc_ctrl

//--- tb/pspc_starter_model.sv
// Auxiliary pump starters that follow the relay contacts
`timescale 1ns/1ns
module pspc_starter_model (
    input wire logic clk_sys, // System clock
    input wire logic rst_n, // Async reset, active low
    input wire logic [3:0] relay_out, // Relay contacts, 1 = closed
    output logic [3:0] pump_run // Starter pulled in
);
    logic [3:0] coil_ff;
    // Two-cycle pick-up, like a contactor coil lagging its contact
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            coil_ff <= 4'h0;
            pump_run <= 4'h0;
        end else begin
            coil_ff <= relay_out;
            pump_run <= coil_ff;
        end
    end
endmodule // pspc_starter_model

//--- tb/pspc_ctrl_test.sv
// Self-checking bench for the pump staging controller
`timescale 1ns/1ns
module pspc_ctrl_test;
    logic clk_sys, rst_n, run_auto, run_manual, press_switch;
    logic [15:0] pressure_meas, master_freq, freq_cap, freq_override;
    logic [3:0] relay_out, pump_run, wstrb;
    logic cap_on, ovr_on, awv, awr, wv, wr, bv, br, arv, arr, rv, rr;
    logic [7:0] awa, ara;
    logic [31:0] wd, rd, rdat;
    logic [1:0] bresp, rresp, resp;
    int n_fail = 0;
    int samples_checked = 0;
    int k;
    pspc_ctrl #(.TICK_CYC(10)) i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
        .run_auto(run_auto), .run_manual(run_manual),
        .press_switch(press_switch), .pressure_meas(pressure_meas),
        .master_freq(master_freq), .relay_out(relay_out),
        .freq_cap(freq_cap), .freq_cap_on(cap_on),
        .freq_override(freq_override), .freq_override_on(ovr_on),
        .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_awaddr(awa),
        .s_axi_wvalid(wv), .s_axi_wready(wr), .s_axi_wdata(wd),
        .s_axi_wstrb(wstrb), .s_axi_bvalid(bv), .s_axi_bready(br),
        .s_axi_bresp(bresp), .s_axi_arvalid(arv), .s_axi_arready(arr),
        .s_axi_araddr(ara), .s_axi_rvalid(rv), .s_axi_rready(rr),
        .s_axi_rdata(rd), .s_axi_rresp(rresp));
    pspc_starter_model i_pumps (.clk_sys(clk_sys), .rst_n(rst_n),
        .relay_out(relay_out), .pump_run(pump_run));
    // Clock and watchdog
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = ~clk_sys;
    end
    initial begin
        #60000;
        n_fail++;
        close_out();
    end
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            $display("MISMATCH %s exp %h got %h", nm, e, g);
            n_fail++;
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys);
    endtask
    // Bus master: holds each channel until its own ready
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        awv <= 1'b1; awa <= a; wv <= 1'b1; wd <= d; br <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (awv && awr) awv <= 1'b0;
            if (wv && wr) wv <= 1'b0;
        end while (!bv);
        br <= 1'b0;
        chk("bresp", 32'h0, {30'h0, bresp});
    endtask
    task automatic rd_reg(input logic [7:0] a);
        @(posedge clk_sys);
        arv <= 1'b1; ara <= a; rr <= 1'b1;
        do begin
            @(posedge clk_sys);
            if (arv && arr) arv <= 1'b0;
        end while (!rv);
        rdat = rd; resp = rresp; rr <= 1'b0;
    endtask
    task automatic t_regs();
        rd_reg(8'h04);
        chk("fill reset", 32'h0, rdat);
        rd_reg(8'h20);
        chk("unmapped resp", 32'h2, {30'h0, resp});
        wr_reg(8'h00, 32'h0000_0A01); tick(4);
        chk("general relays", 32'hA, {28'h0, relay_out});
        wr_reg(8'h00, 32'h0000_0A15); tick(4);
        chk("relays suppressed", 32'h0, {28'h0, relay_out});
        $display("test regs done");
    endtask
    task automatic t_fill_stage();
        // Exit 0x50 below target 0x64, fill pumps within aux count
        wr_reg(8'h04, 32'h0064_0100); wr_reg(8'h08, 32'h0050_0064);
        wr_reg(8'h0C, 32'h000A_000A); wr_reg(8'h10, 32'h0001_0202);
        wr_reg(8'h14, 32'h0010_0020); wr_reg(8'h18, 32'h0000_0005);
        @(posedge clk_sys); pressure_meas <= 16'h3C; run_auto <= 1'b1;
        for (k = 0; k < 20 && cap_on !== 1'b1; k++) tick(1);
        chk("fill start", 32'h1, {31'h0, cap_on});
        chk("fill cap", 32'h100, {16'h0, freq_cap});
        chk("fill relays", 32'h1, {28'h0, relay_out});
        @(posedge clk_sys); pressure_meas <= 16'h55;
        for (k = 0; k < 20 && cap_on !== 1'b0; k++) tick(1);
        chk("fill end", 32'h0, {31'h0, cap_on});
        chk("fill relays off", 32'h0, {28'h0, relay_out});
        for (k = 0; k < 100 && relay_out === 4'h0; k++) tick(1);
        chk("first stage", 32'h1, {28'h0, relay_out});
        tick(3);
        chk("stage hold-off", 32'h1, {28'h0, relay_out});
        for (k = 0; k < 100 && relay_out === 4'h1; k++) tick(1);
        chk("second stage", 32'h3, {28'h0, relay_out});
        tick(60);
        chk("aux count cap", 32'h3, {28'h0, relay_out});
        chk("pumps running", 32'h3, {28'h0, pump_run});
        $display("test fill and stage done");
    endtask
    task automatic t_release();
        @(posedge clk_sys); pressure_meas <= 16'h78; master_freq <= 16'h40;
        tick(60);
        chk("freq outside window", 32'h3, {28'h0, relay_out});
        @(posedge clk_sys); master_freq <= 16'h28;
        for (k = 0; k < 100 && ovr_on !== 1'b1; k++) tick(1);
        pressure_meas <= 16'h64;
        chk("release last", 32'h1, {28'h0, relay_out});
        chk("bump freq", 32'h25, {16'h0, freq_override});
        for (k = 0; k < 40 && ovr_on !== 1'b0; k++) tick(1);
        chk("bump over", 32'h0, {31'h0, ovr_on});
        $display("test release done");
    endtask
    task automatic t_no_fill();
        logic seen;
        @(posedge clk_sys); run_auto <= 1'b0;
        tick(6);
        chk("off relays", 32'h0, {28'h0, relay_out});
        wr_reg(8'h04, 32'h0000_0100);
        @(posedge clk_sys); run_manual <= 1'b1;
        seen = 1'b0;
        repeat (30) begin
            tick(1);
            seen = seen | (cap_on !== 1'b0);
        end
        chk("zero fill time", 32'h0, {31'h0, seen});
        // Switch setup: fill ends once the switch reports pressure
        wr_reg(8'h00, 32'h0000_0A14);
        wr_reg(8'h04, 32'h0064_0100);
        run_manual <= 1'b0;
        tick(6);
        run_manual <= 1'b1;
        tick(8);
        chk("switch fill", 32'h1, {31'h0, cap_on});
        press_switch <= 1'b1;
        tick(6);
        chk("switch end", 32'h0, {31'h0, cap_on});
        $display("test no fill done");
    endtask
    task automatic close_out();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        rst_n = 1'b0; run_auto = 1'b0; run_manual = 1'b0;
        press_switch = 1'b0; pressure_meas = 16'h64; master_freq = 16'h40;
        awv = 1'b0; wv = 1'b0; br = 1'b0; arv = 1'b0; rr = 1'b0;
        awa = 8'h0; ara = 8'h0; wd = 32'h0; wstrb = 4'hF;
        tick(12);
        rst_n <= 1'b1;
        tick(3);
        t_regs();
        t_fill_stage();
        t_release();
        t_no_fill();
        close_out();
    end
endmodule // pspc_ctrl_test
